// ---- rtl/ifd_decoder.sv ----
// Instruction field decoder top: APB registers, decode latch and condition update
`timescale 1ns/1ps
`include "ifd_defs.svh"

module ifd_decoder
(
  // Clock and reset
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_N,
  // APB slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  input  wire logic [3:0]           PSTRB,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // Instruction fetch stage
  input  wire logic                 FETCH_VALID,
  input  wire logic [31:0]          FETCH_INSN,
  // Execution datapath result
  input  ifd_pkg::ifd_result_s      RESULT,
  // Decoded fields towards execution units and register file
  output ifd_pkg::ifd_fields_s      DECODE,
  output logic                      DECODE_VALID,
  output logic                      MODE64,
  // Architectural flags
  output logic      [31:0]          CONDITION_REG,
  output logic                      SUMMARY_OVERFLOW,
  output logic                      OVERFLOW_FLAG
);

  // Address decode, used for reads and for writes
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
    addr_is = (addr == off);
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    merge = res;
  endfunction

  logic                 bus_write;
  logic                 bus_read;
  logic                 addr_known;
  logic                 wr_ctrl;
  logic                 wr_insn;
  logic                 wr_cond;
  logic                 wr_ovf;
  logic                 mode64;
  logic [31:0]          insn;
  logic [31:0]          next_insn;
  logic                 load_insn;
  ifd_pkg::ifd_fields_s next_fields;
  ifd_pkg::ifd_fields_s fields;
  logic                 fields_valid;
  logic [31:0]          condition_register;
  logic                 summary_overflow;
  logic                 overflow_flag;
  logic                 next_summary_overflow;
  logic                 next_overflow_flag;
  logic                 ovf_update;
  logic                 result_negative;
  logic                 result_zero;
  logic                 zero_result_flag;
  logic [3:0]           int_field;
  logic                 cr_update;

  // APB qualifiers: write in the access phase, read in either phase; the slave never waits
  assign bus_write  = PSEL && PENABLE && PWRITE;
  assign bus_read   = PSEL && !PWRITE;
  assign addr_known = addr_is(PADDR, `IFD_CTRL_OFF) || addr_is(PADDR, `IFD_INSN_OFF) ||
                      addr_is(PADDR, `IFD_COND_OFF) || addr_is(PADDR, `IFD_OVF_OFF) ||
                      addr_is(PADDR, `IFD_DEC0_OFF) || addr_is(PADDR, `IFD_DEC1_OFF) ||
                      addr_is(PADDR, `IFD_DEC2_OFF) || addr_is(PADDR, `IFD_DEC3_OFF);
  assign wr_ctrl    = bus_write && addr_is(PADDR, `IFD_CTRL_OFF);
  assign wr_insn    = bus_write && addr_is(PADDR, `IFD_INSN_OFF);
  assign wr_cond    = bus_write && addr_is(PADDR, `IFD_COND_OFF);
  assign wr_ovf     = bus_write && addr_is(PADDR, `IFD_OVF_OFF);

  // Zero wait state answer; error on an unmapped address
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_known;

  // Mode control register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      mode64 <= `IFD_CTRL_RST;
    else if (wr_ctrl && PSTRB[0])
      mode64 <= PWDATA[0];
  end

  // Instruction source: fetch stage wins over a software write in the same cycle
  always_comb
  begin
    load_insn = FETCH_VALID || wr_insn;
    if (FETCH_VALID)
      next_insn = FETCH_INSN;
    else if (wr_insn)
      next_insn = merge(insn, PWDATA, PSTRB);
    else
      next_insn = insn;
  end

  // Held instruction word
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      insn <= `IFD_INSN_RST;
    else if (load_insn)
      insn <= next_insn;
  end

  // Field extraction of the word being loaded
  ifd_field_extract u_extract
  (
    .insn   (next_insn),
    .mode64 (mode64),
    .fields (next_fields)
  );

  // Decoded fields, registered so that they change only on a load
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      fields <= '0;
    else if (load_insn)
      fields <= next_fields;
  end

  // Decode valid: set by any load, cleared by a control register write in a cycle without a load
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      fields_valid <= 1'b0;
    else if (load_insn)
      fields_valid <= 1'b1;
    else if (wr_ctrl)
      fields_valid <= 1'b0;
  end

  // Signed view of the result at the current register width
  always_comb
  begin
    if (mode64)
    begin
      result_negative = RESULT.value[63];
      result_zero     = (RESULT.value == 64'h0000_0000_0000_0000);
    end
    else
    begin
      result_negative = RESULT.value[31];
      result_zero     = (RESULT.value[31:0] == 32'h0000_0000);
    end
    zero_result_flag = result_zero;
  end

  // Overflow and summary overflow, only in the overflow enabled form
  always_comb
  begin
    ovf_update = RESULT.valid && RESULT.oe_form && !RESULT.is_float &&
                 fields.overflow_enable;
    next_overflow_flag    = overflow_flag;
    next_summary_overflow = summary_overflow;
    if (wr_ovf && PSTRB[0])
    begin
      next_summary_overflow = PWDATA[0];
      next_overflow_flag    = PWDATA[1];
    end
    // Hardware update wins for the overflow flag; the summary ORs the overflow into a same-cycle software write
    if (ovf_update)
    begin
      next_overflow_flag    = RESULT.overflow;
      next_summary_overflow = next_summary_overflow || RESULT.overflow;
    end
  end

  // Overflow flag registers
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      summary_overflow <= 1'b0;
      overflow_flag    <= 1'b0;
    end
    else
    begin
      summary_overflow <= next_summary_overflow;
      overflow_flag    <= next_overflow_flag;
    end
  end

  // Integer record field: lt, gt, zero, then summary copy after this result
  assign int_field = {result_negative,
                      !result_negative && !zero_result_flag,
                      zero_result_flag,
                      next_summary_overflow};
  assign cr_update = RESULT.valid && fields.record_bit;

  // Condition register: result update wins over a software write
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      condition_register <= `IFD_COND_RST;
    else if (cr_update && !RESULT.is_float)
      condition_register <= {int_field, condition_register[27:0]};
    else if (cr_update && RESULT.is_float)
      condition_register <= {condition_register[31:28], RESULT.fp_flags,
                             condition_register[23:0]};
    else if (wr_cond)
      condition_register <= merge(condition_register, PWDATA, PSTRB);
    else
      condition_register <= condition_register;
  end

  // Read data, registered in the setup cycle so it stands through the access phase
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      PRDATA <= 32'h0000_0000;
    else if (bus_read && !PENABLE)
    begin
      if (addr_is(PADDR, `IFD_CTRL_OFF))
        PRDATA <= {30'h0000_0000, fields_valid, mode64};
      else if (addr_is(PADDR, `IFD_INSN_OFF))
        PRDATA <= insn;
      else if (addr_is(PADDR, `IFD_COND_OFF))
        PRDATA <= condition_register;
      else if (addr_is(PADDR, `IFD_OVF_OFF))
        PRDATA <= {30'h0000_0000, overflow_flag, summary_overflow};
      else if (addr_is(PADDR, `IFD_DEC0_OFF))
        PRDATA <= {1'b0, fields.overflow_enable, fields.record_bit,
                   fields.segment_register_sel, fields.trap_condition_field,
                   fields.rotate_count_field, fields.operand_b_sel,
                   fields.operand_a_sel, fields.dest_sel};
      else if (addr_is(PADDR, `IFD_DEC1_OFF))
        PRDATA <= {fields.signed_imm16, fields.unsigned_imm16};
      else if (addr_is(PADDR, `IFD_DEC2_OFF))
        PRDATA <= {fields.time_base_high_half, fields.time_base_low_half,
                   fields.special_reg_num, fields.wide_rotate_count,
                   fields.mask_end, fields.extended_opcode_w5,
                   fields.extended_opcode_d3};
      else if (addr_is(PADDR, `IFD_DEC3_OFF))
        PRDATA <= {3'h0, fields.extended_opcode_d2, fields.extended_opcode_d4,
                   fields.extended_opcode_d9, fields.extended_opcode_w9,
                   fields.mask_begin[4:0]};
      else
        PRDATA <= 32'h0000_0000;
    end
  end

  // Outputs come straight from registers
  assign DECODE           = fields;
  assign DECODE_VALID     = fields_valid;
  assign MODE64           = mode64;
  assign CONDITION_REG    = condition_register;
  assign SUMMARY_OVERFLOW = summary_overflow;
  assign OVERFLOW_FLAG    = overflow_flag;

endmodule

// ---- rtl/ifd_defs.svh ----
// Offsets, field positions, reset values and constants of the instruction field decoder
//
// How it works
// - Record bit at position 31 clear leaves the condition register untouched.
// - Integer record: field bits 0-2 give signed lt/gt/zero, bit 3 copies overflow summary.
// - Float record: bits 4-7 take exception, enabled, invalid and overflow flags in order.
// - Bits 6-10 select the destination general register.
// - Bits 6-10 alternatively select a source general register.
// - Bits 16-20 give the plain rotate or shift count.
// - Bits 16-31 form a signed 16-bit immediate.
// - Bits 16-31 form an unsigned 16-bit immediate, never sign extended.
// - In 32-bit mode bits 12-15 pick one of 16 segment registers.
// - Bits 6-10 of trap instructions give the trap comparison conditions.
// - 32-bit opcode extensions at 21-30, 22-30, 26-30; other positions 64-bit only.
// - 64-bit mode: split bits 21-26 give first one bit of rotate mask.
// - 64-bit mode: split bits 21-26 give last one bit of rotate mask.
// - 64-bit mode: wide shift count built from bits 16-20 plus bit 30.
// - Bits 11-20 select the special register for move to and from.
// - Bits 11-20 of time base read select lower or upper time base half.
// - Overflow enable bit 21 lets overflow and its summary flag update.
`ifndef IFD_DEFS_SVH
`define IFD_DEFS_SVH

// Big-endian bit n of the word sits at little-endian index 31-n
`define IFD_LE(n)        (31 - (n))

// Field positions, big-endian numbering
`define IFD_REG_SEL_LAST   10
`define IFD_SEG_LAST       15
`define IFD_RA_LAST        15
`define IFD_RB_LAST        20
`define IFD_IMM_LAST       31
`define IFD_OE_POS         21
`define IFD_MASK_LAST      25
`define IFD_MASK_HI_POS    26
`define IFD_WIDE_HI_POS    30
`define IFD_XO_LAST30      30
`define IFD_XO_LAST29      29
`define IFD_XO_LAST31      31
`define IFD_RECORD_POS     31

// Register byte offsets
`define IFD_CTRL_OFF       12'h000
`define IFD_INSN_OFF       12'h004
`define IFD_COND_OFF       12'h008
`define IFD_OVF_OFF        12'h00c
`define IFD_DEC0_OFF       12'h010
`define IFD_DEC1_OFF       12'h014
`define IFD_DEC2_OFF       12'h018
`define IFD_DEC3_OFF       12'h01c

// Reset values
`define IFD_CTRL_RST       1'b0
`define IFD_INSN_RST       32'h0000_0000
`define IFD_COND_RST       32'h0000_0000

// Time base select numbers after the half swap (plain defaults)
`define IFD_TB_LOW_NUM     10'h001
`define IFD_TB_HIGH_NUM    10'h002

`endif

// ---- rtl/ifd_field_extract.sv ----
// Combinational extraction of the named operand fields from an instruction word
`timescale 1ns/1ps
`include "ifd_defs.svh"

module ifd_field_extract
(
  // Instruction and mode
  input  wire logic [31:0]         insn,
  input  wire logic                mode64,
  // Decoded fields
  output ifd_pkg::ifd_fields_s     fields
);

  logic [4:0]  half_lo;
  logic [4:0]  half_hi;
  logic [9:0]  swapped;
  logic [15:0] imm;

  // Ten-bit select halves, bits 11-15 and 16-20
  assign half_lo = insn[`IFD_LE(`IFD_RA_LAST) +: 5];
  assign half_hi = insn[`IFD_LE(`IFD_RB_LAST) +: 5];
  assign swapped = {half_hi, half_lo};
  assign imm     = insn[`IFD_LE(`IFD_IMM_LAST) +: 16];

  // Field assembly
  always_comb
  begin
    fields = '0;
    fields.dest_sel             = insn[`IFD_LE(`IFD_REG_SEL_LAST) +: 5];
    fields.source_register_sel  = insn[`IFD_LE(`IFD_REG_SEL_LAST) +: 5];
    fields.operand_a_sel        = half_lo;
    fields.operand_b_sel        = half_hi;
    fields.rotate_count_field   = half_hi;
    fields.signed_imm16         = imm;
    fields.unsigned_imm16       = imm;
    // Sign extension reaches 64 bits only in 64-bit mode
    if (mode64)
      fields.signed_imm_ext = {{48{imm[15]}}, imm};
    else
      fields.signed_imm_ext = {32'h0000_0000, {16{imm[15]}}, imm};
    fields.unsigned_imm_ext     = {48'h0000_0000_0000, imm};
    fields.trap_condition_field = insn[`IFD_LE(`IFD_REG_SEL_LAST) +: 5];
    // 32-bit opcode extension positions
    fields.extended_opcode_w10  = insn[`IFD_LE(`IFD_XO_LAST30) +: 10];
    fields.extended_opcode_w9   = insn[`IFD_LE(`IFD_XO_LAST30) +: 9];
    fields.extended_opcode_w5   = insn[`IFD_LE(`IFD_XO_LAST30) +: 5];
    fields.special_reg_num      = swapped;
    fields.time_base_num        = swapped;
    fields.time_base_low_half   = (swapped == `IFD_TB_LOW_NUM);
    fields.time_base_high_half  = (swapped == `IFD_TB_HIGH_NUM);
    fields.record_bit           = insn[`IFD_LE(`IFD_RECORD_POS)];
    fields.overflow_enable      = insn[`IFD_LE(`IFD_OE_POS)];
    if (mode64)
    begin
      // 64-bit only positions; they read zero in 32-bit mode
      fields.extended_opcode_d9 = insn[`IFD_LE(`IFD_XO_LAST29) +: 9];
      fields.extended_opcode_d3 = insn[`IFD_LE(`IFD_XO_LAST29) +: 3];
      fields.extended_opcode_d4 = insn[`IFD_LE(`IFD_XO_LAST30) +: 4];
      fields.extended_opcode_d2 = insn[`IFD_LE(`IFD_XO_LAST31) +: 2];
      fields.mask_begin = {insn[`IFD_LE(`IFD_MASK_HI_POS)],
                           insn[`IFD_LE(`IFD_MASK_LAST) +: 5]};
      fields.mask_end   = {insn[`IFD_LE(`IFD_MASK_HI_POS)],
                           insn[`IFD_LE(`IFD_MASK_LAST) +: 5]};
      fields.wide_rotate_count = {insn[`IFD_LE(`IFD_WIDE_HI_POS)], half_hi};
    end
    else
    begin
      // Segment select exists only in 32-bit mode
      fields.segment_register_sel = insn[`IFD_LE(`IFD_SEG_LAST) +: 4];
    end
  end

endmodule

// ---- rtl/ifd_pkg.sv ----
// Types shared by the instruction field decoder
package ifd_pkg;

  typedef logic [63:0] ifd_word_t;

  // Decoded operand fields of one instruction
  typedef struct packed {
    logic [4:0] dest_sel;
    logic [4:0] source_register_sel;
    logic [4:0] operand_a_sel;
    logic [4:0] operand_b_sel;
    logic [4:0] rotate_count_field;
    logic [15:0] signed_imm16;
    logic [15:0] unsigned_imm16;
    ifd_word_t   signed_imm_ext;
    ifd_word_t   unsigned_imm_ext;
    logic [3:0]  segment_register_sel;
    logic [4:0]  trap_condition_field;
    logic [9:0]  extended_opcode_w10;
    logic [8:0]  extended_opcode_w9;
    logic [4:0]  extended_opcode_w5;
    logic [8:0]  extended_opcode_d9;
    logic [2:0]  extended_opcode_d3;
    logic [3:0]  extended_opcode_d4;
    logic [1:0]  extended_opcode_d2;
    logic [5:0]  mask_begin;
    logic [5:0]  mask_end;
    logic [5:0]  wide_rotate_count;
    logic [9:0]  special_reg_num;
    logic [9:0]  time_base_num;
    logic        time_base_low_half;
    logic        time_base_high_half;
    logic        record_bit;
    logic        overflow_enable;
  } ifd_fields_s;

  // Completed result reported by the execution datapath
  typedef struct packed {
    logic       valid;
    ifd_word_t  value;
    logic       is_float;
    logic       oe_form;
    logic       overflow;
    logic [3:0] fp_flags;
  } ifd_result_s;

endpackage

// ---- test/ifd_decoder_chk.sv ----
// Port-level assertions for the instruction field decoder
`timescale 1ns/1ps
module ifd_decoder_chk
(
  // Clock and reset
  input wire logic                 CORE_CLK,
  input wire logic                 RST_N,
  // Bus write qualifiers
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  // Fetch and result
  input wire logic                 FETCH_VALID,
  input wire logic [31:0]          FETCH_INSN,
  input wire ifd_pkg::ifd_result_s RESULT,
  // Decoded state and flags
  input wire ifd_pkg::ifd_fields_s DECODE,
  input wire logic                 MODE64,
  input wire logic [31:0]          CONDITION_REG,
  input wire logic                 SUMMARY_OVERFLOW,
  input wire logic                 OVERFLOW_FLAG
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // Condition update and flag checks
  a_record_clear_hold: assert property (RESULT.valid && !DECODE.record_bit &&
    !(PSEL && PENABLE && PWRITE) |=> $stable(CONDITION_REG)) else $error("cr moved");
  a_int_cr_flags: assert property (RESULT.valid && DECODE.record_bit &&
    !RESULT.is_float && !MODE64 |=> CONDITION_REG[31:28] == {$past(RESULT.value[31]),
    $past(!RESULT.value[31] && RESULT.value[31:0] != 0), $past(RESULT.value[31:0] == 0),
    SUMMARY_OVERFLOW}) else $error("int cr bad");
  a_fp_cr_flags: assert property (RESULT.valid && DECODE.record_bit && RESULT.is_float
    |=> CONDITION_REG[27:24] == $past(RESULT.fp_flags)) else $error("fp cr bad");
  a_ovf_update: assert property (RESULT.valid && RESULT.oe_form && !RESULT.is_float &&
    DECODE.overflow_enable |=> OVERFLOW_FLAG == $past(RESULT.overflow) &&
    (SUMMARY_OVERFLOW || !$past(RESULT.overflow))) else $error("ovf bad");

  // Field extraction checks, little-endian vector indices
  a_reg_select: assert property (FETCH_VALID |=>
    DECODE.dest_sel == $past(FETCH_INSN[25:21]) && DECODE.source_register_sel ==
    DECODE.dest_sel && DECODE.trap_condition_field == DECODE.dest_sel) else $error("sel bad");
  a_imm_fields: assert property (FETCH_VALID |=>
    DECODE.rotate_count_field == $past(FETCH_INSN[15:11]) && DECODE.signed_imm16 ==
    $past(FETCH_INSN[15:0]) && DECODE.unsigned_imm_ext == {48'h0, $past(FETCH_INSN[15:0])})
    else $error("imm bad");
  a_seg_select: assert property (FETCH_VALID && !MODE64 |=>
    DECODE.segment_register_sel == $past(FETCH_INSN[19:16])) else $error("seg bad");
  a_split_mask: assert property (FETCH_VALID && MODE64 |=>
    DECODE.mask_begin == {$past(FETCH_INSN[5]), $past(FETCH_INSN[10:6])} &&
    DECODE.mask_end == DECODE.mask_begin && DECODE.wide_rotate_count ==
    {$past(FETCH_INSN[1]), $past(FETCH_INSN[15:11])}) else $error("split bad");
  a_opcode_ext: assert property (FETCH_VALID |=>
    DECODE.extended_opcode_w10 == $past(FETCH_INSN[10:1]) &&
    DECODE.extended_opcode_w5 == $past(FETCH_INSN[5:1])) else $error("xo bad");
  a_spr_swap: assert property (FETCH_VALID |=>
    DECODE.special_reg_num == {$past(FETCH_INSN[15:11]), $past(FETCH_INSN[20:16])} &&
    DECODE.time_base_num == DECODE.special_reg_num) else $error("swap bad");

  // Main scenarios reached
  c_int_record: cover property (RESULT.valid && DECODE.record_bit && !RESULT.is_float);
  c_fp_record: cover property (RESULT.valid && DECODE.record_bit && RESULT.is_float);
  c_ovf_set: cover property (RESULT.valid && DECODE.overflow_enable && RESULT.overflow);
endmodule

bind ifd_decoder ifd_decoder_chk chk_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .FETCH_VALID(FETCH_VALID), .FETCH_INSN(FETCH_INSN),
  .RESULT(RESULT), .DECODE(DECODE), .MODE64(MODE64), .CONDITION_REG(CONDITION_REG),
  .SUMMARY_OVERFLOW(SUMMARY_OVERFLOW), .OVERFLOW_FLAG(OVERFLOW_FLAG));

// ---- test/ifd_pipe_model.sv ----
// Behavioural fetch stage and execution datapath facing the decoder
`timescale 1ns/1ps
module ifd_pipe_model
(
  // Clock
  input  wire logic            clk,
  // Towards the decoder
  output logic                 fetch_valid,
  output logic [31:0]          fetch_insn,
  output ifd_pkg::ifd_result_s result
);
  // Quiet lines until the first transfer
  initial
  begin
    fetch_valid = 1'b0;
    fetch_insn  = 32'h0;
    result      = '0;
  end

  // One word after gap idle cycles; stale bits are inverted afterwards
  task automatic fetch(input logic [31:0] w, input int gap);
    repeat (gap) @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_insn  <= w;
    @(posedge clk);
    fetch_valid <= 1'b0;
    fetch_insn  <= ~w;
  endtask

  // One result for one cycle, then valid drops and the payload is scrambled
  task automatic send(input ifd_pkg::ifd_result_s r);
    result <= r;
    @(posedge clk);
    result <= {1'b0, ~r[$bits(r)-2:0]};
  endtask
endmodule

// ---- test/tb_insn_field_decoder.sv ----
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ps
`include "ifd_defs.svh"
module tb_insn_field_decoder;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, fetch_insn, ecr, cond_reg;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, fetch_valid, decode_valid, mode64, sum_ovf, ovf_flag, eso, eov;
  ifd_pkg::ifd_result_s result;
  ifd_pkg::ifd_fields_s decode;
  int seed = 64, miscompares = 0, total_checks = 0;

  // 25 MHz core clock
  always #20 clk = ~clk;

  ifd_decoder dut_u (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FETCH_VALID(fetch_valid), .FETCH_INSN(fetch_insn),
    .RESULT(result), .DECODE(decode), .DECODE_VALID(decode_valid), .MODE64(mode64),
    .CONDITION_REG(cond_reg), .SUMMARY_OVERFLOW(sum_ovf), .OVERFLOW_FLAG(ovf_flag));
  ifd_pipe_model pm_u (.clk(clk), .fetch_valid(fetch_valid), .fetch_insn(fetch_insn),
    .result(result));

  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [299:0] got, input logic [299:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer: setup, access held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 16)
      begin
        miscompares++;
        complete_run();
      end
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Reference field extraction, bit n of the word at vector index 31-n
  function automatic ifd_pkg::ifd_fields_s fld(input logic [31:0] w, input logic m);
    ifd_pkg::ifd_fields_s f;
    f = '0;
    f.dest_sel = w[25:21];
    f.source_register_sel = w[25:21];
    f.trap_condition_field = w[25:21];
    f.operand_a_sel = w[20:16];
    f.operand_b_sel = w[15:11];
    f.rotate_count_field = w[15:11];
    f.signed_imm16 = w[15:0];
    f.unsigned_imm16 = w[15:0];
    f.signed_imm_ext = m ? {{48{w[15]}}, w[15:0]} : {32'h0, {16{w[15]}}, w[15:0]};
    f.unsigned_imm_ext = {48'h0, w[15:0]};
    f.extended_opcode_w10 = w[10:1];
    f.extended_opcode_w9 = w[9:1];
    f.extended_opcode_w5 = w[5:1];
    if (m)
    begin
      f.extended_opcode_d9 = w[10:2];
      f.extended_opcode_d3 = w[4:2];
      f.extended_opcode_d4 = w[4:1];
      f.extended_opcode_d2 = w[1:0];
      f.mask_begin = {w[5], w[10:6]};
      f.mask_end = {w[5], w[10:6]};
      f.wide_rotate_count = {w[1], w[15:11]};
    end
    else
      f.segment_register_sel = w[19:16];
    f.special_reg_num = {w[15:11], w[20:16]};
    f.time_base_num = {w[15:11], w[20:16]};
    f.time_base_low_half = f.time_base_num == `IFD_TB_LOW_NUM;
    f.time_base_high_half = f.time_base_num == `IFD_TB_HIGH_NUM;
    f.record_bit = w[0];
    f.overflow_enable = w[10];
    return f;
  endfunction

  // Main sequence
  initial
  begin : main
    logic [31:0] rd, w, t;
    logic err, neg, zr;
    ifd_pkg::ifd_fields_s f;
    ifd_pkg::ifd_result_s r;
    logic [31:0] dir [4];
    dir = '{32'h0001_0000, 32'h0002_0000, 32'hffff_ffff, 32'h0000_8401};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, lane merge, overflow register and an unmapped place
    apb(1'b0, `IFD_INSN_OFF, 32'h0, 4'hf, rd, err);
    check(rd, `IFD_INSN_RST);
    w = $random(seed);
    apb(1'b1, `IFD_COND_OFF, w, 4'b0101, rd, err);
    ecr = {8'h0, w[23:16], 8'h0, w[7:0]};
    apb(1'b0, `IFD_COND_OFF, 32'h0, 4'hf, rd, err);
    check(rd, ecr);
    for (int v = 3; v >= 0; v -= 3)
    begin
      apb(1'b1, `IFD_OVF_OFF, v, 4'hf, rd, err);
      apb(1'b0, `IFD_OVF_OFF, 32'h0, 4'hf, rd, err);
      check(rd, v);
    end
    {eso, eov} = 2'b00;
    apb(1'b0, 12'h020, 32'h0, 4'hf, rd, err);
    check({err, rd}, {1'b1, 32'h0});
    // Decode and condition updates in both word widths
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, `IFD_CTRL_OFF, m, 4'hf, rd, err);
      check({mode64, decode_valid}, {m[0], 1'b0});
      for (int i = 0; i < 24; i++)
      begin
        w = (i < 4) ? dir[i] : $random(seed);
        t = $random(seed);
        f = fld(w, m[0]);
        r.valid = 1'b1;
        r.value = (i % 5 == 0) ? 64'h0 : {$random(seed), $random(seed)};
        {r.fp_flags, r.overflow, r.oe_form, r.is_float} = t[6:0];
        if (r.oe_form && !r.is_float && f.overflow_enable)
        begin
          eov = r.overflow;
          eso = eso | r.overflow;
        end
        if (f.record_bit && r.is_float)
          ecr[27:24] = r.fp_flags;
        else if (f.record_bit)
        begin
          neg = m ? r.value[63] : r.value[31];
          zr = m ? r.value == 64'h0 : r.value[31:0] == 32'h0;
          ecr[31:28] = {neg, !neg && !zr, zr, eso};
        end
        pm_u.fetch(w, i % 3);
        pm_u.send(r);
        @(negedge clk);
        check(decode, f);
        check(decode_valid, 1'b1);
        check({cond_reg, sum_ovf, ovf_flag}, {ecr, eso, eov});
        @(posedge clk);
      end
      apb(1'b1, `IFD_DEC1_OFF, 32'h0, 4'hf, rd, err);
      apb(1'b0, `IFD_DEC1_OFF, 32'h0, 4'hf, rd, err);
      check(rd, {w[15:0], w[15:0]});
      apb(1'b0, `IFD_DEC0_OFF, 32'h0, 4'hf, rd, err);
      check(rd, {1'b0, f.overflow_enable, f.record_bit, f.segment_register_sel,
        f.trap_condition_field, f.rotate_count_field, f.operand_b_sel, f.operand_a_sel,
        f.dest_sel});
    end
    complete_run();
  end
endmodule
